// ---- pkg/atseq_pkg.sv ----
// Package for the acquisition trigger sequencer: modes, states, carriers, defaults
`default_nettype none
package atseq_pkg;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned SAMP_W  = 12;
  localparam int unsigned LINE_W  = 11;
  localparam logic [CNT_W-1:0]  HOLDOFF_DEFAULT = 16'h0000;
  localparam logic [CNT_W-1:0]  DELAY_DEFAULT   = 16'h0000;
  localparam logic [LINE_W-1:0] LINE_DEFAULT    = 11'h001;
  localparam logic [LINE_W-1:0] LINE_FIRST      = 11'h001;

  typedef enum logic [1:0] {
    ATSEQ_SRC_IMMEDIATE = 2'h0,
    ATSEQ_SRC_SOFTWARE  = 2'h1,
    ATSEQ_SRC_EXTERNAL  = 2'h2
  } atseq_arm_src_e;

  typedef enum logic [1:0] {
    ATSEQ_REF_SOFTWARE = 2'h0,
    ATSEQ_REF_VIDEO    = 2'h1,
    ATSEQ_REF_WINDOW   = 2'h2
  } atseq_ref_mode_e;

  typedef enum logic [6:0] {
    ATSEQ_IDLE    = 7'h01,
    ATSEQ_WSTART  = 7'h02,
    ATSEQ_PRE     = 7'h04,
    ATSEQ_WREF    = 7'h08,
    ATSEQ_DELAY   = 7'h10,
    ATSEQ_POST    = 7'h20,
    ATSEQ_DONE    = 7'h40
  } atseq_state_e;

  typedef struct packed {
    logic              hsync;      // Line sync pulse, active level as sampled
    logic              vsync;      // Field sync pulse
    logic [15:0]       sample;     // Video sample value
  } atseq_video_s;

  typedef struct packed {
    logic [1:0]        sync_format_select; // Expected sync format code
    logic              sync_polarity;      // 1: positive-going sync
    logic              event_specific;     // 1: fire on target line
    logic [10:0]       target_line_index;  // Line within frame
    logic              clamp_to_zero_enable;
  } atseq_video_cfg_s;
endpackage
`default_nettype wire

// ---- rtl/atseq_sequencer.sv ----
// Acquisition trigger sequencer: start, pretrigger, reference trigger, posttrigger
// Overview of operation
// - After initiate, wait for start trigger, then collect pretrigger samples.
// - Start source immediate by default: start condition already met.
// - Reference trigger detection armed only after pretrigger count reached.
// - After reference trigger, collect posttrigger samples then flag complete.
// - After any trigger, ignore triggers until holdoff elapses; default zero.
// - After accepted trigger, wait delay before acquiring; default zero.
// - Software mode: host command acts as reference trigger.
// - Video mode fires only on valid sync of set format and polarity.
// - Video event chooses specific line or next line/field.
// - Specific line counts lines across frame; target defaults to 1.
// - Clamp enable shifts each line so clamp portion sits at zero.
// - Window mode fires on entering or leaving low/high band.
// - Records after the first start on advance source, default immediate.
`default_nettype none
module atseq_sequencer #(
  parameter int unsigned CNT_W  = atseq_pkg::CNT_W,
  parameter int unsigned SAMP_W = atseq_pkg::SAMP_W
) (
  input  wire logic                       clock,          // 10 MHz sample clock
  input  wire logic                       rst_b,          // Sync reset, active low
  input  wire logic                       initiate,       // Start acquisition pulse
  input  wire logic                       abort,          // Return to idle
  input  wire atseq_pkg::atseq_arm_src_e  arm_src,        // Start trigger source
  input  wire atseq_pkg::atseq_arm_src_e  adv_src,        // Advance trigger source
  input  wire atseq_pkg::atseq_ref_mode_e ref_mode,       // Reference trigger type
  input  wire logic                       sw_start,       // Software start/advance pulse
  input  wire logic                       ext_start,      // External start/advance level
  input  wire logic                       sw_trigger,     // Software reference trigger
  input  wire logic [SAMP_W-1:0]          pre_count,      // Pretrigger samples
  input  wire logic [SAMP_W-1:0]          post_count,     // Posttrigger samples
  input  wire logic [7:0]                 num_records,    // Records, 0 read as 1
  input  wire logic [CNT_W-1:0]           holdoff_cycles, // Holdoff in clocks
  input  wire logic [CNT_W-1:0]           delay_cycles,   // Delay in clocks
  input  wire atseq_pkg::atseq_video_s    video,          // Video input
  input  wire atseq_pkg::atseq_video_cfg_s vcfg,          // Video settings
  input  wire logic [1:0]                 sync_format_in, // Detected sync format
  input  wire logic [15:0]                clamp_level,    // Measured clamp level
  input  wire logic                       clamp_valid,    // Clamp window sample
  input  wire logic [15:0]                win_low,        // Window low threshold
  input  wire logic [15:0]                win_high,       // Window high threshold
  input  wire logic                       win_leave,      // 1: fire on leaving
  output logic                            sampling,       // Sample capture enable
  output logic                            ref_armed,      // Reference detection armed
  output logic                            trig_accepted,  // Reference accepted pulse
  output logic                            complete,       // Acquisition complete
  output logic                            busy,           // Neither idle nor complete
  output logic [7:0]                      record_idx,     // Current record
  output logic [15:0]                     video_out,      // Clamped video sample
  output logic [10:0]                     line_count      // Line within frame
);
  // ==========================================================
  // State and counters
  atseq_pkg::atseq_state_e state;
  atseq_pkg::atseq_state_e next_state;
  logic [SAMP_W-1:0] samp_cnt;
  logic [CNT_W-1:0]  holdoff_cnt;
  logic [CNT_W-1:0]  delay_cnt;
  logic              start_ok;
  logic              ref_event;
  logic              raw_trig;
  logic              last_rec;
  logic              hsync_q;
  logic              vsync_q;
  logic              in_band;
  logic              in_band_q;

  function automatic logic src_met(input atseq_pkg::atseq_arm_src_e s,
                                   input logic sw, input logic ext);
    unique case (s)
      atseq_pkg::ATSEQ_SRC_IMMEDIATE: src_met = 1'b1;
      atseq_pkg::ATSEQ_SRC_SOFTWARE:  src_met = sw;
      default:                        src_met = ext;
    endcase
  endfunction

  // ==========================================================
  // Trigger sources
  logic sync_ok;
  logic hs_edge;
  logic vs_edge;
  assign sync_ok = (sync_format_in == vcfg.sync_format_select);
  assign hs_edge = (video.hsync == vcfg.sync_polarity) && (hsync_q != vcfg.sync_polarity);
  assign vs_edge = (video.vsync == vcfg.sync_polarity) && (vsync_q != vcfg.sync_polarity);
  assign in_band = (video_out >= win_low) && (video_out <= win_high);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      hsync_q   <= 1'b0;
      vsync_q   <= 1'b0;
      in_band_q <= 1'b0;
    end
    else
    begin
      hsync_q   <= video.hsync;
      vsync_q   <= video.vsync;
      in_band_q <= in_band;
    end
  end

  // Frame-wide line counter restarts at the first line on each field sync
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      line_count <= atseq_pkg::LINE_FIRST;
    else if (vs_edge)
      line_count <= atseq_pkg::LINE_FIRST;
    else if (hs_edge)
      line_count <= line_count + 11'h001;
  end

  always_comb
  begin
    unique case (ref_mode)
      atseq_pkg::ATSEQ_REF_SOFTWARE: raw_trig = sw_trigger;
      atseq_pkg::ATSEQ_REF_VIDEO:
        // Fires as the target line begins; the first line begins at the field sync
        if (vcfg.event_specific)
          raw_trig = sync_ok && (vs_edge
                       ? (vcfg.target_line_index == atseq_pkg::LINE_FIRST)
                       : (hs_edge && (line_count + 11'h001 == vcfg.target_line_index)));
        else
          raw_trig = sync_ok && (hs_edge || vs_edge);
      default:
        raw_trig = win_leave ? (in_band_q && !in_band) : (!in_band_q && in_band);
    endcase
  end

  // Triggers inside the holdoff window are discarded, not queued
  assign ref_event = raw_trig && (holdoff_cnt == '0) && (state == atseq_pkg::ATSEQ_WREF);

  // ==========================================================
  // Clamp: offset so the clamp portion of each line reads as zero
  logic [15:0] clamp_off;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      clamp_off <= 16'h0000;
    else if (clamp_valid)
      clamp_off <= clamp_level;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      video_out <= 16'h0000;
    else
      video_out <= vcfg.clamp_to_zero_enable ? video.sample - clamp_off : video.sample;
  end

  // ==========================================================
  // Sequencer
  assign last_rec = (record_idx + 8'h01 >= num_records);
  assign start_ok = (record_idx == 8'h00) ? src_met(arm_src, sw_start, ext_start)
                                          : src_met(adv_src, sw_start, ext_start);

  always_comb
  begin
    next_state = state;
    unique case (state)
      atseq_pkg::ATSEQ_IDLE:   if (initiate) next_state = atseq_pkg::ATSEQ_WSTART;
      atseq_pkg::ATSEQ_WSTART: if (start_ok) next_state = atseq_pkg::ATSEQ_PRE;
      atseq_pkg::ATSEQ_PRE:    if (samp_cnt + 1'b1 >= pre_count || pre_count == '0)
                                 next_state = atseq_pkg::ATSEQ_WREF;
      atseq_pkg::ATSEQ_WREF:   if (ref_event)
                                 next_state = (delay_cycles == '0) ? atseq_pkg::ATSEQ_POST
                                                                   : atseq_pkg::ATSEQ_DELAY;
      atseq_pkg::ATSEQ_DELAY:  if (delay_cnt == CNT_W'(1)) next_state = atseq_pkg::ATSEQ_POST;
      atseq_pkg::ATSEQ_POST:   if (samp_cnt + 1'b1 >= post_count || post_count == '0)
                                 next_state = last_rec ? atseq_pkg::ATSEQ_DONE
                                                       : atseq_pkg::ATSEQ_WSTART;
      atseq_pkg::ATSEQ_DONE:   if (initiate) next_state = atseq_pkg::ATSEQ_WSTART;
      default:                 next_state = atseq_pkg::ATSEQ_IDLE;
    endcase
    if (abort)
      next_state = atseq_pkg::ATSEQ_IDLE;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      state <= atseq_pkg::ATSEQ_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b || next_state != state)
      samp_cnt <= '0;
    else if (state == atseq_pkg::ATSEQ_PRE || state == atseq_pkg::ATSEQ_POST)
      samp_cnt <= samp_cnt + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b || state == atseq_pkg::ATSEQ_IDLE || state == atseq_pkg::ATSEQ_DONE)
      record_idx <= 8'h00;
    else if (state == atseq_pkg::ATSEQ_POST && next_state == atseq_pkg::ATSEQ_WSTART)
      record_idx <= record_idx + 8'h01;
  end

  // Holdoff starts from any trigger detected while holdoff is zero, even one that is not accepted
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      holdoff_cnt <= atseq_pkg::HOLDOFF_DEFAULT;
    else if (raw_trig && holdoff_cnt == '0)
      holdoff_cnt <= holdoff_cycles;
    else if (holdoff_cnt != '0)
      holdoff_cnt <= holdoff_cnt - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      delay_cnt <= atseq_pkg::DELAY_DEFAULT;
    else if (ref_event)
      delay_cnt <= delay_cycles;
    else if (delay_cnt != '0)
      delay_cnt <= delay_cnt - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      trig_accepted <= 1'b0;
    else
      trig_accepted <= ref_event;
  end

  assign sampling  = (state == atseq_pkg::ATSEQ_PRE) || (state == atseq_pkg::ATSEQ_WREF)
                  || (state == atseq_pkg::ATSEQ_POST);
  assign ref_armed = (state == atseq_pkg::ATSEQ_WREF);
  assign complete  = (state == atseq_pkg::ATSEQ_DONE);
  assign busy      = (state != atseq_pkg::ATSEQ_IDLE) && !complete;

  // ==========================================================
  // Assertions
  property p_start_hold;
    @(posedge clock) disable iff (!rst_b)
      (state == atseq_pkg::ATSEQ_WSTART && !start_ok && !abort) |=> !sampling;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("sampling before start");

  property p_immediate;
    @(posedge clock) disable iff (!rst_b)
      (state == atseq_pkg::ATSEQ_WSTART && record_idx == 8'h00
       && arm_src == atseq_pkg::ATSEQ_SRC_IMMEDIATE && !abort)
      |=> state == atseq_pkg::ATSEQ_PRE;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate start stalled");

  property p_arm_after_pre;
    @(posedge clock) disable iff (!rst_b)
      $rose(ref_armed) |-> $past(state) == atseq_pkg::ATSEQ_PRE;
  endproperty
  a_arm_after_pre: assert property (p_arm_after_pre) else $error("armed too early");

  property p_done_after_post;
    @(posedge clock) disable iff (!rst_b)
      $rose(complete) |-> $past(state) == atseq_pkg::ATSEQ_POST;
  endproperty
  a_done_after_post: assert property (p_done_after_post) else $error("bad complete");

  property p_holdoff;
    @(posedge clock) disable iff (!rst_b)
      (holdoff_cnt != '0) |-> !ref_event;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("trigger within holdoff");

  property p_delay;
    @(posedge clock) disable iff (!rst_b)
      (ref_event && delay_cycles == CNT_W'(2) && !abort) |=> !sampling ##1 !abort [*1]
        ##0 (state == atseq_pkg::ATSEQ_DELAY);
  endproperty
  a_delay: assert property (p_delay) else $error("delay not applied");

  property p_sw;
    @(posedge clock) disable iff (!rst_b)
      (ref_mode == atseq_pkg::ATSEQ_REF_SOFTWARE && ref_armed && sw_trigger
       && holdoff_cnt == '0) |=> trig_accepted;
  endproperty
  a_sw: assert property (p_sw) else $error("software trigger lost");

  property p_window;
    @(posedge clock) disable iff (!rst_b)
      (ref_mode == atseq_pkg::ATSEQ_REF_WINDOW && ref_event) |->
        (in_band != in_band_q) && (in_band == !win_leave);
  endproperty
  a_window: assert property (p_window) else $error("window trigger wrong");

  property p_video;
    @(posedge clock) disable iff (!rst_b)
      (ref_mode == atseq_pkg::ATSEQ_REF_VIDEO && ref_event) |-> sync_ok;
  endproperty
  a_video: assert property (p_video) else $error("video trigger without sync");

  c_done:    cover property (@(posedge clock) disable iff (!rst_b) $rose(complete));
  c_video:   cover property (@(posedge clock) disable iff (!rst_b)
               ref_event && ref_mode == atseq_pkg::ATSEQ_REF_VIDEO);
  c_multi:   cover property (@(posedge clock) disable iff (!rst_b) record_idx == 8'h02);
  c_delayed: cover property (@(posedge clock) disable iff (!rst_b)
               state == atseq_pkg::ATSEQ_DELAY);
endmodule
`default_nettype wire

// ---- testbench/atseq_host_model.sv ----
// Host software model: holds commands as one-clock pulses for the sequencer
`default_nettype none
module atseq_host_model (
  input  wire logic clock,      // Sample clock
  output logic      initiate,   // Acquisition start command
  output logic      abort,      // Abort command
  output logic      sw_start,   // Software start or advance command
  output logic      sw_trigger  // Software reference trigger command
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    {initiate, abort, sw_start, sw_trigger} = 4'h0;
  end

  // ==========================================================
  // Command pulses
  // Launched just after an edge and held across exactly one sampling edge
  // Only the commanded lines are touched, so back-to-back calls never rewrite one line
  task automatic pulse(input logic [3:0] mask);
    if (mask[3]) initiate = 1'b1;
    if (mask[2]) abort = 1'b1;
    if (mask[1]) sw_start = 1'b1;
    if (mask[0]) sw_trigger = 1'b1;
    @(posedge clock);
    #5;
    if (mask[3]) initiate = 1'b0;
    if (mask[2]) abort = 1'b0;
    if (mask[1]) sw_start = 1'b0;
    if (mask[0]) sw_trigger = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/acquisition_trigger_sequencer_bench.sv ----
// Self-checking bench for the acquisition trigger sequencer
`default_nettype none
module acquisition_trigger_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clock, rst_b, ext_start, clamp_valid, win_leave;
  logic                         initiate, abort, sw_start, sw_trigger;
  atseq_pkg::atseq_arm_src_e    arm_src, adv_src;
  atseq_pkg::atseq_ref_mode_e   ref_mode;
  logic [11:0]                  pre_count, post_count;
  logic [7:0]                   num_records, record_idx;
  logic [15:0]                  holdoff_cycles, delay_cycles, clamp_level, win_low, win_high;
  atseq_pkg::atseq_video_s      vid;
  atseq_pkg::atseq_video_cfg_s  vcfg;
  logic [1:0]                   sync_format_in;
  logic                         sampling, ref_armed, trig_accepted, complete, busy;
  logic [15:0]                  video_out;
  logic [10:0]                  line_count;
  int                           mismatches, n_checks, n, s, d;
  logic                         got;

  atseq_host_model host_i (.clock(clock), .initiate(initiate), .abort(abort),
    .sw_start(sw_start), .sw_trigger(sw_trigger));

  atseq_sequencer atseq_sequencer_i (.clock(clock), .rst_b(rst_b), .initiate(initiate),
    .abort(abort), .arm_src(arm_src), .adv_src(adv_src), .ref_mode(ref_mode),
    .sw_start(sw_start), .ext_start(ext_start), .sw_trigger(sw_trigger),
    .pre_count(pre_count), .post_count(post_count), .num_records(num_records),
    .holdoff_cycles(holdoff_cycles), .delay_cycles(delay_cycles), .video(vid),
    .vcfg(vcfg), .sync_format_in(sync_format_in), .clamp_level(clamp_level),
    .clamp_valid(clamp_valid), .win_low(win_low), .win_high(win_high),
    .win_leave(win_leave), .sampling(sampling), .ref_armed(ref_armed),
    .trig_accepted(trig_accepted), .complete(complete), .busy(busy),
    .record_idx(record_idx), .video_out(video_out), .line_count(line_count));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #5;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    n_checks++;
    if (a !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic count_pre(output int c);
    int k;
    c = 0;
    for (k = 0; k < 100 && ref_armed !== 1'b1; k++)
    begin
      if (sampling === 1'b1) c++;
      tick(1);
    end
  endtask
  // Sampling cycles and idle delay cycles from trigger to completion
  task automatic count_tail(output int cs, output int cd);
    int k;
    cs = 0;
    cd = 0;
    for (k = 0; k < 200 && complete !== 1'b1; k++)
    begin
      if (sampling === 1'b1) cs++;
      if ({busy, sampling, ref_armed} === 3'b100) cd++;
      tick(1);
    end
  endtask
  task automatic wait_acc(input int lim);
    int k;
    for (k = 0; k < lim && trig_accepted !== 1'b1; k++) tick(1);
  endtask
  task automatic sync_pulse(input bit field);
    if (field) vid.vsync = 1'b1; else vid.hsync = 1'b1;
    tick(1);
    // The accept pulse stands for one cycle only, so catch it here
    got = trig_accepted;
    vid.vsync = 1'b0;
    vid.hsync = 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    {rst_b, ext_start, clamp_valid, win_leave, clamp_level} = '0;
    {arm_src, adv_src, ref_mode} = '0;
    {pre_count, post_count, num_records, holdoff_cycles, delay_cycles} = '0;
    {vid, vcfg, sync_format_in, win_low, win_high} = '0;
    mismatches = 0;
    n_checks = 0;
    tick(10);
    rst_b = 1'b1;
    chk(16'h0000, {busy, sampling, ref_armed, trig_accepted, complete, record_idx});
    chk(16'h0001, 16'(line_count));
    $display("test reset done");
    // Early trigger dropped, counted pre and post, zero and nonzero delay
    for (int dl = 0; dl < 5; dl += 2)
    begin
      pre_count = 12'h003;
      post_count = 12'h002;
      delay_cycles = 16'(dl);
      host_i.pulse(4'h8);
      host_i.pulse(4'h1);
      chk(16'h0000, 16'(trig_accepted));
      count_pre(n);
      chk(16'h0003, 16'(n));
      host_i.pulse(4'h1);
      chk(16'h0001, 16'(trig_accepted));
      count_tail(s, d);
      chk(16'h0002, 16'(s));
      chk(16'(dl), 16'(d));
      chk(16'h0001, 16'(complete));
    end
    $display("test basic done");
    delay_cycles = 16'h0000;
    holdoff_cycles = 16'h0014;
    host_i.pulse(4'h8);
    host_i.pulse(4'h1);
    count_pre(n);
    host_i.pulse(4'h1);
    chk(16'h0000, 16'(trig_accepted));
    tick(20);
    host_i.pulse(4'h1);
    chk(16'h0001, 16'(trig_accepted));
    count_tail(s, d);
    holdoff_cycles = 16'h0000;
    tick(25);
    $display("test holdoff done");
    arm_src = atseq_pkg::ATSEQ_SRC_SOFTWARE;
    host_i.pulse(4'h8);
    tick(6);
    chk(16'h0001, {15'h0000, busy & ~sampling});
    host_i.pulse(4'h2);
    for (int k = 0; k < 3 && sampling !== 1'b1; k++) tick(1);
    chk(16'h0001, 16'(sampling));
    host_i.pulse(4'h4);
    chk(16'h0000, 16'(busy));
    arm_src = atseq_pkg::ATSEQ_SRC_EXTERNAL;
    host_i.pulse(4'h8);
    tick(3);
    chk(16'h0001, {15'h0000, busy & ~sampling});
    ext_start = 1'b1;
    tick(1);
    chk(16'h0001, 16'(sampling));
    ext_start = 1'b0;
    host_i.pulse(4'h4);
    chk(16'h0000, 16'(busy));
    $display("test start source done");
    arm_src = atseq_pkg::ATSEQ_SRC_IMMEDIATE;
    adv_src = atseq_pkg::ATSEQ_SRC_SOFTWARE;
    num_records = 8'h02;
    host_i.pulse(4'h8);
    count_pre(n);
    host_i.pulse(4'h1);
    for (int k = 0; k < 20 && record_idx !== 8'h01; k++) tick(1);
    tick(5);
    chk(16'h0001, {15'h0000, busy & ~sampling});
    host_i.pulse(4'h2);
    count_pre(n);
    host_i.pulse(4'h1);
    count_tail(s, d);
    chk(16'h0001, 16'(complete));
    num_records = 8'h01;
    $display("test records done");
    ref_mode = atseq_pkg::ATSEQ_REF_WINDOW;
    win_low = 16'h1000;
    win_high = 16'h2000;
    for (int m = 0; m < 2; m++)
    begin
      win_leave = m[0];
      vid.sample = m ? 16'h1800 : 16'h0800;
      host_i.pulse(4'h8);
      count_pre(n);
      tick(3);
      chk(16'h0000, 16'(trig_accepted));
      vid.sample = m ? 16'h3000 : 16'h1800;
      wait_acc(5);
      chk(16'h0001, 16'(trig_accepted));
      count_tail(s, d);
    end
    $display("test window done");
    ref_mode = atseq_pkg::ATSEQ_REF_VIDEO;
    vcfg.sync_format_select = 2'h1;
    vcfg.sync_polarity = 1'b1;
    sync_format_in = 2'h2;
    host_i.pulse(4'h8);
    count_pre(n);
    sync_pulse(1'b0);
    chk(16'h0000, 16'(got));
    sync_format_in = 2'h1;
    sync_pulse(1'b0);
    chk(16'h0001, 16'(got));
    count_tail(s, d);
    vcfg.event_specific = 1'b1;
    vcfg.target_line_index = 11'h003;
    host_i.pulse(4'h8);
    count_pre(n);
    sync_pulse(1'b1);
    sync_pulse(1'b0);
    chk(16'h0002, {got, 4'h0, line_count});
    sync_pulse(1'b0);
    chk(16'h8003, {got, 4'h0, line_count});
    count_tail(s, d);
    $display("test video done");
    vid.sample = 16'h0150;
    tick(2);
    chk(16'h0150, video_out);
    vcfg.clamp_to_zero_enable = 1'b1;
    clamp_level = 16'h0100;
    clamp_valid = 1'b1;
    tick(1);
    clamp_valid = 1'b0;
    tick(2);
    chk(16'h0050, video_out);
    $display("test clamp done");
    give_verdict();
  end
endmodule
`default_nettype wire
